// ==== rtl/sequencer_defines.svh ====
// Offsets, field positions, reset values and timing counts of the debug sequencer
`ifndef SEQUENCER_DEFINES_SVH
`define SEQUENCER_DEFINES_SVH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define ADDR_W 12
`define OFF_CTRL 12'h000
`define OFF_RX_START 12'h004
`define OFF_FILT_BASE 12'h020
`define FILT_WORDS 6
`define OFF_JCTRL 12'h040
`define OFF_JSTAT 12'h044
`define OFF_DOUT0 12'h048
`define OFF_DOUT1 12'h04c
`define OFF_DOUT2 12'h050
`define OFF_DOUT3 12'h054
`define OFF_CAP0 12'h058
`define OFF_CAP1 12'h05c
`define MEM_WINDOW 2'h1

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define CTRL_EN_BIT 0
`define CTRL_DMA_BIT 1
`define CTRL_RESET 2'h0
`define JCTRL_TRST_BIT 0
`define JCTRL_RESET 32'h00000000
`define STAT_IDLE_BIT 2
`define FILT_EXT_BIT 29
`define DEBUG_CFG 3'h7
`define KIND_A 2'h1
`define KIND_B 2'h2
`define KIND_C 2'h3
`define ELEM_DLC 4'h8

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_NS 4
`define TCK_HALF_NS 12
`define TCK_HALF_CYC ((`TCK_HALF_NS + `CLK_NS - 1) / `CLK_NS)
`define SCAN_BITS 60

`endif

// ==== rtl/sequencer_pkg.sv ====
// Types shared by the debug sequencer modules
package sequencer_pkg;
    typedef enum logic [1:0] {
        ORD_IDLE = 2'h0,
        ORD_GOT_A = 2'h1,
        ORD_GOT_B = 2'h3
    } order_state_type;

    typedef enum logic [1:0] {
        SC_IDLE = 2'h0,
        SC_LOW = 2'h1,
        SC_HIGH = 2'h3
    } scan_state_type;
endpackage

// ==== rtl/sequencer_if.sv ====
// Carriers between the sequencer top, its buffer memory and its scan engine
interface rx_mem_if;
    logic we;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [7:0] raddr;
    logic [31:0] rdata;
    modport owner (output we, waddr, wdata, raddr, input rdata);
    modport store (input we, waddr, wdata, raddr, output rdata);
endinterface

interface scan_if;
    logic start;
    logic [59:0] tms_bits;
    logic [59:0] tdi_bits;
    logic tdo_sync;
    logic busy;
    logic done;
    logic [59:0] capture;
    modport ctl (output start, tms_bits, tdi_bits, tdo_sync, input busy, done, capture);
    modport eng (input start, tms_bits, tdi_bits, tdo_sync, output busy, done, capture);
endinterface

// ==== rtl/rx_buffer_mem.sv ====
// Receive buffer memory: 64 elements of four words, registered read
module rx_buffer_mem (
    input logic clk,
    rx_mem_if.store port
);
    logic [31:0] mem [0:255];
    logic [31:0] rdata_r;

    always_ff @(posedge clk) begin
        if (port.we) begin
            mem[port.waddr] <= port.wdata;
        end
        rdata_r <= mem[port.raddr];
    end

    assign port.rdata = rdata_r;
endmodule

// ==== rtl/jtag_scan_engine.sv ====
// Scan engine: plays 60 TMS/TDI bits on a divided TCK and captures TDO
`include "sequencer_defines.svh"

module jtag_scan_engine (
    input logic clk,
    input logic rst,
    scan_if.eng sc,
    output logic tck,
    output logic tms,
    output logic tdi
);
    sequencer_pkg::scan_state_type state_r;
    logic [7:0] div_r;
    logic [5:0] cnt_r;
    logic [59:0] tms_sh_r;
    logic [59:0] tdi_sh_r;
    logic [59:0] cap_r;
    logic tck_r;
    logic done_r;
    wire logic tick = (div_r == 8'(`TCK_HALF_CYC - 1));
    wire logic last = (cnt_r == 6'(`SCAN_BITS - 1));

    // ****************************************************************
    // Sequencing
    // ****************************************************************
    // TDO is sampled on the rising TCK, a whole half period after the
    // target changed it, which covers the two-stage synchroniser delay
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= sequencer_pkg::SC_IDLE;
            div_r <= 8'h00;
            cnt_r <= 6'h00;
            tms_sh_r <= 60'h0;
            tdi_sh_r <= 60'h0;
            cap_r <= 60'h0;
            tck_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            div_r <= (tick || state_r == sequencer_pkg::SC_IDLE) ? 8'h00 : div_r + 8'h01;
            unique case (state_r)
                sequencer_pkg::SC_IDLE: begin
                    if (sc.start) begin
                        tms_sh_r <= sc.tms_bits;
                        tdi_sh_r <= sc.tdi_bits;
                        cnt_r <= 6'h00;
                        state_r <= sequencer_pkg::SC_LOW;
                    end
                end
                sequencer_pkg::SC_LOW: begin
                    if (tick) begin
                        tck_r <= 1'b1;
                        cap_r <= {cap_r[58:0], sc.tdo_sync};
                        state_r <= sequencer_pkg::SC_HIGH;
                    end
                end
                sequencer_pkg::SC_HIGH: begin
                    if (tick) begin
                        tck_r <= 1'b0;
                        tms_sh_r <= {tms_sh_r[58:0], 1'b0};
                        tdi_sh_r <= {tdi_sh_r[58:0], 1'b0};
                        cnt_r <= cnt_r + 6'h01;
                        if (last) begin
                            done_r <= 1'b1;
                            state_r <= sequencer_pkg::SC_IDLE;
                        end else begin
                            state_r <= sequencer_pkg::SC_LOW;
                        end
                    end
                end
                default: begin
                    state_r <= sequencer_pkg::SC_IDLE;
                end
            endcase
        end
    end

    assign tck = tck_r;
    assign tms = tms_sh_r[59];
    assign tdi = tdi_sh_r[59];
    assign sc.busy = (state_r != sequencer_pkg::SC_IDLE);
    assign sc.done = done_r;
    assign sc.capture = cap_r;
endmodule

// ==== rtl/can_debug_message_sequencer.sv ====
// Debug frame filter, order checker, receive store and internal JTAG master
`include "sequencer_defines.svh"

// How it works
// - Debug cycle is frames A, B, C in order; other frames may interleave.
// - Filter with element config 111 marks debug frame; stored in receive buffer.
// - Filter type field of a debug filter is ignored.
// - Second id bits 10:9 classify frame: 01 A, 10 B, 11 C.
// - Second id bits 5:0 plus buffer start give storage element index.
// - Second id bits 8:6 drive the filter event outputs.
// - Stored id: extended flag with 29 bits, or standard id in 28:18.
// - Receive element is 16 bytes; eight payload bytes feed the JTAG master.
// - Order state is readable as a field of the JTAG master status.
// - Out-of-order debug frame is rejected and order state returns to 00.
// - Good frame C raises the DMA request when DMA triggering is enabled.
// - Writing output word 3 bit 0 sets send flag and starts JTAG traffic.
// - JTAG master drives TCK, TMS, TDI and test reset; accepts TDO.
module can_debug_message_sequencer (
    input logic clk,
    input logic rst,
    input logic [11:0] bus_addr,
    input logic [31:0] bus_wdata,
    input logic bus_wr,
    input logic bus_rd,
    output logic [31:0] bus_rdata,
    input logic rx_valid,
    input logic rx_ext,
    input logic [28:0] rx_id,
    input logic [63:0] rx_data,
    output logic dma_req,
    output logic [2:0] filter_event,
    output logic frame_rejected,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input logic tdo
);
    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic filter_match(
        input logic [31:0] w0,
        input logic [31:0] w1,
        input logic ext,
        input logic [28:0] id
    );
        logic is_ext;
        logic id_eq;
        is_ext = w1[`FILT_EXT_BIT];
        // Bits 31:30 of the second word are the filter type and play no part here
        id_eq = is_ext ? (id == w0[28:0]) : (id[28:18] == w0[10:0]);
        filter_match = (w0[31:29] == `DEBUG_CFG) && (is_ext == ext) && id_eq;
    endfunction

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
        addr_is = (a == off);
    endfunction

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [1:0] ctrl_r;
    logic [5:0] rx_start_r;
    logic [31:0] filt_r [0:5];
    logic [31:0] jctrl_r;
    logic [23:0] jstat_user_r;
    logic [31:0] dout_r [0:3];
    logic send_r;
    logic [31:0] cap0_r;
    logic [31:0] cap1_r;
    logic [31:0] rdata_r;
    logic mem_rd_r;
    sequencer_pkg::order_state_type order_r;
    sequencer_pkg::order_state_type order_nxt;
    logic dma_req_r;
    logic [2:0] event_r;
    logic reject_r;
    logic [127:0] elem_sh_r;
    logic [7:0] store_addr_r;
    logic [2:0] store_left_r;
    logic tdo_meta_r;
    logic tdo_sync_r;

    rx_mem_if mem_bus ();
    scan_if scan_bus ();

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire logic ctrl_en = ctrl_r[`CTRL_EN_BIT];
    wire logic ctrl_dma = ctrl_r[`CTRL_DMA_BIT];
    wire logic filt_sel = (bus_addr[11:5] == `OFF_FILT_BASE >> 5) && (bus_addr[4:2] < 3'h6);
    wire logic [2:0] filt_widx = bus_addr[4:2];
    wire logic mem_sel = (bus_addr[11:10] == `MEM_WINDOW);
    wire logic scan_busy = scan_bus.busy;
    // Output words are decoded in pairs by full address, so control and status writes leave them alone
    wire logic dout_wr = bus_wr
        && (addr_is(bus_addr, `OFF_DOUT0) || addr_is(bus_addr, `OFF_DOUT1));
    wire logic dout_hi_wr = bus_wr
        && (addr_is(bus_addr, `OFF_DOUT2) || addr_is(bus_addr, `OFF_DOUT3));
    wire logic dout3_wr = bus_wr && addr_is(bus_addr, `OFF_DOUT3);
    wire logic scan_start = dout3_wr && bus_wdata[0] && !scan_busy;
    wire logic [31:0] stat_word = {jstat_user_r, 5'h00, !scan_busy, order_r};

    // ****************************************************************
    // Filter lookup
    // ****************************************************************
    logic hit_any;
    logic [1:0] hit_idx;
    always_comb begin
        hit_any = 1'b0;
        hit_idx = 2'h0;
        for (int i = 2; i >= 0; i--) begin
            if (filter_match(filt_r[2 * i], filt_r[2 * i + 1], rx_ext, rx_id)) begin
                hit_any = 1'b1;
                hit_idx = 2'(i);
            end
        end
    end

    wire logic [2:0] w0_idx = {hit_idx, 1'b0};
    wire logic [2:0] w1_idx = {hit_idx, 1'b1};
    wire logic [31:0] hit_w1 = filt_r[w1_idx];
    wire logic [1:0] kind = hit_w1[10:9];
    wire logic [5:0] buf_idx = hit_w1[5:0];
    wire logic [2:0] evt_bits = hit_w1[8:6];
    wire logic [5:0] elem_idx = 6'(rx_start_r + buf_idx);
    wire logic store_busy = (store_left_r != 3'h0);
    wire logic matched = rx_valid && ctrl_en && hit_any && (kind != 2'h0);
    // A frame landing while the previous one is still being written is dropped;
    // frames on the link are far longer than the four store cycles
    wire logic frame_hit = matched && !store_busy;
    wire logic [28:0] stored_id = rx_ext ? rx_id : {rx_id[28:18], 18'h0};
    wire logic [31:0] elem_w0 = {1'b0, rx_ext, 1'b0, stored_id};
    wire logic [31:0] elem_w1 = {1'b0, 7'(w0_idx), 4'h0, `ELEM_DLC, 16'h0000};

    // ****************************************************************
    // Order checking
    // ****************************************************************
    logic in_order;
    always_comb begin
        in_order = 1'b0;
        order_nxt = order_r;
        unique case (order_r)
            sequencer_pkg::ORD_IDLE: begin
                in_order = (kind == `KIND_A);
                if (frame_hit) begin
                    order_nxt = in_order ? sequencer_pkg::ORD_GOT_A : sequencer_pkg::ORD_IDLE;
                end
            end
            sequencer_pkg::ORD_GOT_A: begin
                in_order = (kind == `KIND_B);
                if (frame_hit) begin
                    order_nxt = in_order ? sequencer_pkg::ORD_GOT_B : sequencer_pkg::ORD_IDLE;
                end
            end
            sequencer_pkg::ORD_GOT_B: begin
                in_order = (kind == `KIND_C);
                if (frame_hit) begin
                    order_nxt = sequencer_pkg::ORD_IDLE;
                end
            end
            default: begin
                order_nxt = sequencer_pkg::ORD_IDLE;
            end
        endcase
    end

    wire logic accept = frame_hit && in_order;
    wire logic reject = frame_hit && !in_order;

    always_ff @(posedge clk) begin
        if (rst) begin
            order_r <= sequencer_pkg::ORD_IDLE;
            dma_req_r <= 1'b0;
            event_r <= 3'h0;
            reject_r <= 1'b0;
        end else begin
            order_r <= order_nxt;
            dma_req_r <= accept && (kind == `KIND_C) && ctrl_dma;
            event_r <= matched ? evt_bits : 3'h0;
            reject_r <= reject;
        end
    end

    // ****************************************************************
    // Receive element store
    // ****************************************************************
    // One word per cycle: id, header, payload bytes 3..0, payload bytes 7..4
    always_ff @(posedge clk) begin
        if (rst) begin
            elem_sh_r <= 128'h0;
            store_addr_r <= 8'h00;
            store_left_r <= 3'h0;
        end else if (accept) begin
            elem_sh_r <= {rx_data, elem_w1, elem_w0};
            store_addr_r <= {elem_idx, 2'h0};
            store_left_r <= 3'h4;
        end else if (store_busy) begin
            elem_sh_r <= {32'h0, elem_sh_r[127:32]};
            store_addr_r <= store_addr_r + 8'h01;
            store_left_r <= store_left_r - 3'h1;
        end
    end

    assign mem_bus.we = store_busy;
    assign mem_bus.waddr = store_addr_r;
    assign mem_bus.wdata = elem_sh_r[31:0];
    assign mem_bus.raddr = bus_addr[9:2];

    rx_buffer_mem u_mem (
        .clk(clk),
        .port(mem_bus.owner)
    );

    // ****************************************************************
    // Software registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= `CTRL_RESET;
            rx_start_r <= 6'h00;
            jctrl_r <= `JCTRL_RESET;
            jstat_user_r <= 24'h000000;
        end else if (bus_wr) begin
            if (addr_is(bus_addr, `OFF_CTRL)) begin
                ctrl_r <= bus_wdata[1:0];
            end
            if (addr_is(bus_addr, `OFF_RX_START)) begin
                rx_start_r <= bus_wdata[5:0];
            end
            if (addr_is(bus_addr, `OFF_JCTRL)) begin
                jctrl_r <= bus_wdata;
            end
            if (addr_is(bus_addr, `OFF_JSTAT)) begin
                jstat_user_r <= bus_wdata[31:8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < `FILT_WORDS; i++) begin
                filt_r[i] <= 32'h00000000;
            end
        end else if (bus_wr && filt_sel) begin
            filt_r[filt_widx] <= bus_wdata;
        end
    end

    // Output words feed the scan engine only at start, so rewriting them
    // during a scan prepares the next one without disturbing this one
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                dout_r[i] <= 32'h00000000;
            end
        end else if (dout_wr || dout_hi_wr) begin
            dout_r[bus_addr[3:2] + 2'h2] <= bus_wdata;
        end
    end

    // ****************************************************************
    // Scan control and capture
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            send_r <= 1'b0;
            cap0_r <= 32'h00000000;
            cap1_r <= 32'h00000000;
        end else begin
            if (scan_start) begin
                send_r <= 1'b1;
            end else if (scan_bus.done) begin
                send_r <= 1'b0;
            end
            if (scan_bus.done) begin
                cap0_r <= scan_bus.capture[59:28];
                cap1_r <= {scan_bus.capture[27:0], 4'h0};
            end
        end
    end

    // TDO comes back from the TAP on the divided clock, so it is resynchronised
    always_ff @(posedge clk) begin
        if (rst) begin
            tdo_meta_r <= 1'b0;
            tdo_sync_r <= 1'b0;
        end else begin
            tdo_meta_r <= tdo;
            tdo_sync_r <= tdo_meta_r;
        end
    end

    assign scan_bus.start = scan_start;
    assign scan_bus.tms_bits = {dout_r[0], dout_r[1][31:4]};
    assign scan_bus.tdi_bits = {dout_r[2], bus_wdata[31:4]};
    assign scan_bus.tdo_sync = tdo_sync_r;

    jtag_scan_engine u_scan (
        .clk(clk),
        .rst(rst),
        .sc(scan_bus.ctl),
        .tck(tck),
        .tms(tms),
        .tdi(tdi)
    );

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (filt_sel) begin
            rd_mux = filt_r[filt_widx];
        end else begin
            unique case (bus_addr)
                `OFF_CTRL: rd_mux = {30'h0, ctrl_r};
                `OFF_RX_START: rd_mux = {26'h0, rx_start_r};
                `OFF_JCTRL: rd_mux = jctrl_r;
                `OFF_JSTAT: rd_mux = stat_word;
                `OFF_DOUT0: rd_mux = dout_r[0];
                `OFF_DOUT1: rd_mux = dout_r[1];
                `OFF_DOUT2: rd_mux = dout_r[2];
                `OFF_DOUT3: rd_mux = {dout_r[3][31:1], send_r};
                `OFF_CAP0: rd_mux = cap0_r;
                `OFF_CAP1: rd_mux = cap1_r;
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 32'h00000000;
            mem_rd_r <= 1'b0;
        end else begin
            rdata_r <= bus_rd ? rd_mux : 32'h00000000;
            mem_rd_r <= bus_rd && mem_sel;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign bus_rdata = mem_rd_r ? mem_bus.rdata : rdata_r;
    assign dma_req = dma_req_r;
    assign filter_event = event_r;
    assign frame_rejected = reject_r;
    assign trst_n = jctrl_r[`JCTRL_TRST_BIT];
endmodule

// ==== tb/can_tool_model.sv ====
// Behavioural stand-in for the external debug tool feeding received frames
module can_tool_model (
    input logic clk,
    output logic rx_valid,
    output logic rx_ext,
    output logic [28:0] rx_id,
    output logic [63:0] rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_valid = 1'b0;
        rx_ext = 1'b0;
        rx_id = 29'h0;
        rx_data = 64'h0;
    end
    // One frame per call; the caller picks the order, out-of-order frames included, and waits out the store
    task automatic send(input logic ext, input logic [28:0] id, input logic [63:0] data);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_ext <= ext;
        rx_id <= id;
        rx_data <= data;
        @(posedge clk);
        rx_valid <= 1'b0;
        // Idle fields flip so nothing can lean on a stale frame
        rx_ext <= ~ext;
        rx_id <= ~id;
        rx_data <= ~data;
    endtask
endmodule

// ==== tb/sequencer_chk.sv ====
// Port-level assertions for the debug sequencer
`include "sequencer_defines.svh"
module sequencer_chk (
    input logic clk,
    input logic rst,
    input logic [11:0] bus_addr,
    input logic [31:0] bus_wdata,
    input logic bus_wr,
    input logic bus_rd,
    input logic [31:0] bus_rdata,
    input logic rx_valid,
    input logic dma_req,
    input logic [2:0] filter_event,
    input logic frame_rejected,
    input logic tck,
    input logic tms,
    input logic tdi,
    input logic trst_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence tck_high_phase;
        tck [*3] ##1 !tck;
    endsequence
    sequence jctrl_write;
        bus_wr && bus_addr == `OFF_JCTRL;
    endsequence
    chk_rdata_idle:
        assert property (!$past(bus_rd) |-> bus_rdata == 32'h0) else $error("stray read data");
    chk_req_cause:
        assert property (dma_req |-> $past(rx_valid)) else $error("request without frame");
    chk_reject_cause:
        assert property (frame_rejected |-> $past(rx_valid)) else $error("reject without frame");
    chk_req_not_reject:
        assert property (!(dma_req && frame_rejected)) else $error("request and reject together");
    chk_event_cause:
        assert property (filter_event != 3'h0 |-> $past(rx_valid)) else $error("stray event");
    chk_tck_high:
        assert property ($rose(tck) |-> tck_high_phase) else $error("tck high phase wrong");
    chk_data_steady:
        assert property (tck && $past(tck) |-> $stable(tms) && $stable(tdi))
            else $error("tms or tdi moved while tck high");
    chk_trst_follow:
        assert property (jctrl_write |=> trst_n == $past(bus_wdata[0])) else $error("trst_n stale");
endmodule
bind can_debug_message_sequencer sequencer_chk chk (.clk(clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .rx_valid(rx_valid), .dma_req(dma_req), .filter_event(filter_event),
    .frame_rejected(frame_rejected), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));

// ==== tb/can_debug_message_sequencer_bench.sv ====
// Self-checking bench for the debug sequencer
`include "sequencer_defines.svh"
module can_debug_message_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] bus_addr = 12'h0;
    logic [31:0] bus_wdata = 32'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [31:0] bus_rdata, rd;
    logic rx_valid, rx_ext, dma_req, frame_rejected, tck, tms, tdi, trst_n;
    logic [28:0] rx_id;
    logic [63:0] rx_data;
    logic [2:0] filter_event;
    wire [4:0] pulses = {dma_req, frame_rejected, filter_event};
    int err_total = 0;
    int check_count = 0;
    // ****************************************************************
    // Harness
    // ****************************************************************
    // The TAP stand-in returns tms xor tdi, so both lines reach the captures
    can_debug_message_sequencer DUT (.clk(clk), .rst(rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .rx_valid(rx_valid), .rx_ext(rx_ext), .rx_id(rx_id), .rx_data(rx_data),
        .dma_req(dma_req), .filter_event(filter_event), .frame_rejected(frame_rejected),
        .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tms ^ tdi));
    can_tool_model tool (.clk(clk), .rx_valid(rx_valid), .rx_ext(rx_ext), .rx_id(rx_id),
        .rx_data(rx_data));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic final_report;
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 rd = bus_rdata;
    endtask
    // Pulses are looked at in their one cycle; the store window is then waited out
    task automatic step(input logic e, input logic [28:0] id, input logic [4:0] p, input logic [1:0] s);
        tool.send(e, id, 64'h0123456789abcdef);
        #1 check({27'h0, pulses}, {27'h0, p});
        repeat (4) @(posedge clk);
        rd_reg(`OFF_JSTAT);
        check({30'h0, rd[1:0]}, {30'h0, s});
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_setup;
        logic [31:0] f [6] = '{32'hfabc0001, 32'h60000340, 32'he0000123, 32'h80000481,
            32'he0000c0c, 32'he00007c2};
        rd_reg(12'h3fc);
        check(rd, 32'h0);
        rd_reg(`OFF_JSTAT);
        check(rd & 32'h7, 32'h4);
        wr(`OFF_CTRL, 32'h3);
        wr(`OFF_RX_START, 32'h3d);
        for (int i = 0; i < 6; i++) begin
            wr(`OFF_FILT_BASE + 12'(4 * i), f[i]);
        end
    endtask
    task automatic t_order;
        step(1'b1, 29'h1abc0001, 5'h05, 2'h1);
        step(1'b1, 29'h00000777, 5'h00, 2'h1);
        step(1'b0, 29'h048c0000, 5'h02, 2'h3);
        step(1'b1, 29'h00000c0c, 5'h17, 2'h0);
        rd_reg(12'h7d0);
        check(rd, 32'h5abc0001);
        rd_reg(12'h7d4);
        check(rd & 32'h000f0000, 32'h00080000);
        rd_reg(12'h7e0);
        check(rd, 32'h048c0000);
        rd_reg(12'h7fc);
        check(rd, 32'h01234567);
        step(1'b0, 29'h048c0000, 5'h0a, 2'h0);
        step(1'b1, 29'h1abc0001, 5'h05, 2'h1);
        step(1'b1, 29'h00000c0c, 5'h0f, 2'h0);
        wr(`OFF_CTRL, 32'h1);
        step(1'b1, 29'h1abc0001, 5'h05, 2'h1);
        step(1'b0, 29'h048c0000, 5'h02, 2'h3);
        step(1'b1, 29'h00000c0c, 5'h07, 2'h0);
    endtask
    // Stands in for the six transfers: read-back first, then loads, then the send start
    task automatic t_scan;
        rd_reg(`OFF_JSTAT);
        check(rd, 32'h00000004);
        rd_reg(`OFF_CAP0);
        check(rd, 32'h0);
        rd_reg(`OFF_CAP1);
        check(rd, 32'h0);
        wr(`OFF_JCTRL, 32'h1);
        #1 check({31'h0, trst_n}, 32'h1);
        wr(`OFF_JSTAT, 32'ha5a5a500);
        wr(`OFF_DOUT0, 32'h5a3cc3a5);
        wr(`OFF_DOUT1, 32'h0f1e2d3c);
        wr(`OFF_DOUT2, 32'hc3a55a3c);
        wr(`OFF_DOUT3, 32'h9617e2d1);
        rd_reg(`OFF_JSTAT);
        check(rd & 32'hfffffffc, 32'ha5a5a500);
        rd_reg(`OFF_DOUT3);
        check(rd, 32'h9617e2d1);
        // Like the tool waiting for frames D and E, poll until the scan is over
        for (int i = 0; i < 300 && rd[2] !== 1'b1; i++) begin
            rd_reg(`OFF_JSTAT);
        end
        check(rd & 32'h4, 32'h4);
        rd_reg(`OFF_CAP0);
        check(rd, 32'h99999999);
        rd_reg(`OFF_CAP1);
        check(rd, 32'h9909cfe0);
        rd_reg(`OFF_DOUT2);
        check(rd, 32'hc3a55a3c);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_setup();
        t_order();
        t_scan();
        final_report();
    end
    // Whole run is about five hundred cycles; this is well beyond that
    initial begin
        #60000;
        err_total++;
        final_report();
    end
endmodule
